// ===== verilog/sccr_pkg.sv
package sccr_pkg;
   // ------------------------------------------------------------
   // Register addresses, index is the channel number
   // ------------------------------------------------------------
   localparam logic [1:0][19:0] ADDR_ERRCLR = {20'hF010A, 20'hF0108};
   localparam logic [1:0][19:0] ADDR_SCRL   = {20'hF011A, 20'hF0118};
   localparam logic [1:0][19:0] ADDR_SCRH   = {20'hF011B, 20'hF0119};
   localparam logic [1:0][19:0] ADDR_DBUF   = {20'hFFF12, 20'hFFF10};
   localparam logic [1:0][19:0] ADDR_DIV    = {20'hFFF13, 20'hFFF11};

   // ------------------------------------------------------------
   // Reset values and writable masks
   // ------------------------------------------------------------
   localparam logic [7:0] SCRL_RST   = 8'h87;
   localparam logic [7:0] SCRH_RST   = 8'h00;
   localparam logic [7:0] DATA_RST   = 8'h00;
   localparam logic [7:0] SCRH_WMASK = 8'hF7;
   localparam logic [7:0] SCRL_ONES  = 8'h06;
   localparam logic [1:0][7:0] SCRL_WMASK = {8'h91, 8'hB1};
   localparam logic [1:0]      FE_PRESENT = 2'h2;

   // ------------------------------------------------------------
   // Field positions
   // ------------------------------------------------------------
   localparam int TXE_BIT = 7;
   localparam int RXE_BIT = 6;
   localparam int DAP_BIT = 5;
   localparam int CKP_BIT = 4;
   localparam int EOC_BIT = 2;
   localparam int PTC_LSB = 0;
   localparam int DIR_BIT = 7;
   localparam int SLC_LSB = 4;
   localparam int DLS_BIT = 0;
   localparam int FECT_BIT = 2;
   localparam int PECT_BIT = 1;
   localparam int OVCT_BIT = 0;

   // Parity field codes
   localparam logic [1:0] PAR_EVEN = 2'h2;
   localparam logic [1:0] PAR_ODD  = 2'h3;

   // All channel state, registered in one place
   typedef struct packed {
      logic [1:0][7:0] scr_lo;
      logic [1:0][7:0] scr_hi;
      logic [1:0][7:0] dbuf;
      logic [1:0][7:0] div;
      logic [1:0][7:0] e0;
      logic [1:0][7:0] e1;
      logic [1:0][7:0] cnt;
      logic [1:0]      v0;
      logic [1:0]      v1;
      logic [1:0]      fe;
      logic [1:0]      pe;
      logic [1:0]      ov;
      logic [1:0]      tick;
      logic [1:0]      xirq;
      logic [1:0]      rirq;
      logic [1:0]      eirq;
      logic [1:0]      par;
      logic [1:0]      s1;
      logic [1:0]      s2;
      logic [1:0]      s3;
      logic [7:0]      rdata;
   } sccr_state_type;
endpackage : sccr_pkg

// ===== verilog/sccr_regs.sv
// Function
// - Select 0 gives transfer-end irq, 1 buffer-empty irq on shifter load.
// - Reset loads setting high byte 00H and low byte 87H.
// - Transmit/receive enable pair: off, receive, transmit, both.
// - Error mask 1 sends errors to error interrupt, not receive interrupt.
// - Parity field: none, constant zero, even, odd; last two checked.
// - Bit order 0 shifts MSB first, 1 shifts LSB first.
// - Stop field: none, one, two (channel 0 only); code 11 prohibited.
// - Transfer-end interrupt comes only after all stop bits are shifted.
// - Data length 0 keeps seven bits, 1 keeps eight bits.
// - Reset clears divider byte and data buffer byte.
// - Clock select 0 uses internal divider, 1 uses serial clock pin.
// - Divider writes ignored and reads zero while channel enabled.
// - Data buffer holds received data and feeds transmit data to shifter.
// - Writing 1 to a clear trigger clears its error flag at once unless a set arrives in the same cycle.
// - Clear trigger register always reads zero.
`timescale 1ns/1ps
module sccr_regs (
   input  wire logic                 ref_clk_in,
   input  wire logic                 rst_in,
   input  wire logic [19:0]          bus_addr_in,
   input  wire logic                 bus_wr_in,
   input  wire logic                 bus_rd_in,
   input  wire logic [7:0]           bus_wdata_in,
   output logic      [7:0]           bus_rdata_out,
   input  wire logic [1:0]           channel_enabled_status_in,
   input  wire logic [1:0]           irq_source_select_in,
   input  wire logic [1:0]           transfer_clock_select_in,
   input  wire logic [1:0]           serial_clock_pin_in,
   input  wire logic [1:0]           tx_ready_in,
   input  wire logic [1:0]           rx_valid_in,
   input  wire logic [1:0][7:0]      rx_data_in,
   input  wire logic [1:0]           xfer_end_in,
   input  wire logic [1:0]           framing_set_in,
   input  wire logic [1:0]           parity_set_in,
   input  wire logic [1:0]           overrun_set_in,
   output logic      [1:0][7:0]      tx_data_out,
   output logic      [1:0]           tx_valid_out,
   output logic      [1:0]           tx_buf_ready_out,
   output logic      [1:0]           tx_parity_bit_out,
   output logic      [1:0]           tx_enable_bit_out,
   output logic      [1:0]           rx_enable_bit_out,
   output logic      [1:0]           data_phase_bit_out,
   output logic      [1:0]           clock_phase_bit_out,
   output logic      [1:0]           error_irq_mask_bit_out,
   output logic      [1:0][1:0]      parity_mode_out,
   output logic      [1:0]           bit_order_bit_out,
   output logic      [1:0][1:0]      stop_mode_out,
   output logic      [1:0]           data_length_bit_out,
   output logic      [1:0]           transfer_tick_out,
   output logic      [1:0]           framing_error_flag_out,
   output logic      [1:0]           parity_error_flag_out,
   output logic      [1:0]           overrun_error_flag_out,
   output logic      [1:0]           transfer_irq_out,
   output logic      [1:0]           receive_interrupt_out,
   output logic      [1:0]           error_interrupt_out
);

   sccr_pkg::sccr_state_type s_r;
   sccr_pkg::sccr_state_type s_nxt;

   // ------------------------------------------------------------
   // Next-state logic for both channels
   // ------------------------------------------------------------
   always_comb begin : p_next
      logic       en;
      logic       pop;
      logic       push;
      logic       err;
      logic       ovbuf;
      logic [7:0] wdat;
      logic [7:0] rdat;
      en    = 1'b0;
      pop   = 1'b0;
      push  = 1'b0;
      err   = 1'b0;
      ovbuf = 1'b0;
      wdat  = 8'h00;
      rdat  = 8'h00;
      s_nxt = s_r;
      s_nxt.rdata = 8'h00;
      for (int ch = 0; ch < 2; ch++) begin
         en = channel_enabled_status_in[ch];
         // Setting bytes; fixed bits keep their wired values
         if (bus_wr_in && bus_addr_in == sccr_pkg::ADDR_SCRH[ch]) begin
            s_nxt.scr_hi[ch] = bus_wdata_in & sccr_pkg::SCRH_WMASK;
         end
         if (bus_wr_in && bus_addr_in == sccr_pkg::ADDR_SCRL[ch]) begin
            s_nxt.scr_lo[ch] = (bus_wdata_in & sccr_pkg::SCRL_WMASK[ch])
                               | sccr_pkg::SCRL_ONES;
         end
         // Divider frozen while running so the baud cannot glitch
         if (bus_wr_in && bus_addr_in == sccr_pkg::ADDR_DIV[ch] && !en) begin
            s_nxt.div[ch] = bus_wdata_in;
         end
         // Two-entry transmit buffer, head always in e0
         pop = s_r.v0[ch] && tx_ready_in[ch];
         if (pop) begin
            s_nxt.e0[ch] = s_r.e1[ch];
            s_nxt.v0[ch] = s_r.v1[ch];
            s_nxt.v1[ch] = 1'b0;
         end
         wdat = s_r.scr_lo[ch][sccr_pkg::DLS_BIT] ? bus_wdata_in
                : {1'b0, bus_wdata_in[6:0]};
         push = bus_wr_in && bus_addr_in == sccr_pkg::ADDR_DBUF[ch] && en
                && s_r.scr_hi[ch][sccr_pkg::TXE_BIT];
         if (bus_wr_in && bus_addr_in == sccr_pkg::ADDR_DBUF[ch] && en) begin
            s_nxt.dbuf[ch] = wdat;
         end
         ovbuf = 1'b0;
         if (push) begin
            if (!s_nxt.v0[ch]) begin
               s_nxt.e0[ch] = wdat;
               s_nxt.v0[ch] = 1'b1;
            end else if (!s_nxt.v1[ch]) begin
               s_nxt.e1[ch] = wdat;
               s_nxt.v1[ch] = 1'b1;
            end else begin
               ovbuf = 1'b1; // Full: word dropped, flagged as overrun
            end
         end
         // Received word lands in the buffer byte
         if (rx_valid_in[ch] && s_r.scr_hi[ch][sccr_pkg::RXE_BIT]) begin
            s_nxt.dbuf[ch] = s_r.scr_lo[ch][sccr_pkg::DLS_BIT]
                             ? rx_data_in[ch]
                             : {1'b0, rx_data_in[ch][6:0]};
         end
         // Error flags: a set in the clearing cycle wins
         if (bus_wr_in && bus_addr_in == sccr_pkg::ADDR_ERRCLR[ch]) begin
            if (bus_wdata_in[sccr_pkg::FECT_BIT]) s_nxt.fe[ch] = 1'b0;
            if (bus_wdata_in[sccr_pkg::PECT_BIT]) s_nxt.pe[ch] = 1'b0;
            if (bus_wdata_in[sccr_pkg::OVCT_BIT]) s_nxt.ov[ch] = 1'b0;
         end
         s_nxt.fe[ch] = (s_nxt.fe[ch] | framing_set_in[ch])
                        & sccr_pkg::FE_PRESENT[ch];
         s_nxt.pe[ch] = s_nxt.pe[ch] | parity_set_in[ch];
         s_nxt.ov[ch] = s_nxt.ov[ch] | overrun_set_in[ch] | ovbuf;
         err = framing_set_in[ch] | parity_set_in[ch] | overrun_set_in[ch]
               | ovbuf;
         // Interrupt routing; shifter reports end only after last stop bit
         s_nxt.xirq[ch] = irq_source_select_in[ch] ? pop
                          : xfer_end_in[ch];
         s_nxt.eirq[ch] = s_r.scr_hi[ch][sccr_pkg::EOC_BIT] && err;
         s_nxt.rirq[ch] = rx_valid_in[ch]
                          && !(s_r.scr_hi[ch][sccr_pkg::EOC_BIT] && err);
         // Serial clock pin synchroniser
         s_nxt.s1[ch] = serial_clock_pin_in[ch];
         s_nxt.s2[ch] = s_r.s1[ch];
         s_nxt.s3[ch] = s_r.s2[ch];
         // Transfer clock: pin edge or divided operating clock
         s_nxt.tick[ch] = 1'b0;
         if (!en) begin
            s_nxt.cnt[ch] = 8'h00;
         end else if (transfer_clock_select_in[ch]) begin
            s_nxt.tick[ch] = s_r.s2[ch] && !s_r.s3[ch];
         end else if (s_r.cnt[ch] == 8'h00) begin
            s_nxt.tick[ch] = 1'b1;
            s_nxt.cnt[ch]  = {s_r.div[ch][7:1], 1'b1};
         end else begin
            s_nxt.cnt[ch] = s_r.cnt[ch] - 8'h01;
         end
         // Parity of the head word, held ready for the shifter
         unique case (s_r.scr_hi[ch][sccr_pkg::PTC_LSB +: 2])
            sccr_pkg::PAR_EVEN: s_nxt.par[ch] = ^s_nxt.e0[ch];
            sccr_pkg::PAR_ODD:  s_nxt.par[ch] = ~^s_nxt.e0[ch];
            default:            s_nxt.par[ch] = 1'b0;
         endcase
         // Registered read data, unmapped reads give zero
         rdat = 8'h00;
         if (bus_addr_in == sccr_pkg::ADDR_SCRL[ch]) rdat = s_r.scr_lo[ch];
         if (bus_addr_in == sccr_pkg::ADDR_SCRH[ch]) rdat = s_r.scr_hi[ch];
         if (bus_addr_in == sccr_pkg::ADDR_DBUF[ch]) rdat = s_r.dbuf[ch];
         if (bus_addr_in == sccr_pkg::ADDR_DIV[ch] && !en) begin
            rdat = s_r.div[ch];
         end
         if (bus_rd_in) s_nxt.rdata = s_nxt.rdata | rdat;
      end
   end

   // ------------------------------------------------------------
   // State register
   // ------------------------------------------------------------
   always_ff @(posedge ref_clk_in) begin : p_state
      if (rst_in) begin
         s_r        <= '0;
         s_r.scr_lo <= {sccr_pkg::SCRL_RST, sccr_pkg::SCRL_RST};
         s_r.scr_hi <= {sccr_pkg::SCRH_RST, sccr_pkg::SCRH_RST};
         s_r.div    <= {sccr_pkg::DATA_RST, sccr_pkg::DATA_RST};
         s_r.dbuf   <= {sccr_pkg::DATA_RST, sccr_pkg::DATA_RST};
      end else begin
         s_r <= s_nxt;
      end
   end

   // ------------------------------------------------------------
   // Outputs, all taken from state flops
   // ------------------------------------------------------------
   assign bus_rdata_out = s_r.rdata;
   for (genvar g = 0; g < 2; g++) begin : g_out
      assign tx_data_out[g]            = s_r.e0[g];
      assign tx_valid_out[g]           = s_r.v0[g];
      assign tx_buf_ready_out[g]       = !s_r.v1[g];
      assign tx_parity_bit_out[g]      = s_r.par[g];
      assign tx_enable_bit_out[g]      = s_r.scr_hi[g][sccr_pkg::TXE_BIT];
      assign rx_enable_bit_out[g]      = s_r.scr_hi[g][sccr_pkg::RXE_BIT];
      assign data_phase_bit_out[g]     = s_r.scr_hi[g][sccr_pkg::DAP_BIT];
      assign clock_phase_bit_out[g]    = s_r.scr_hi[g][sccr_pkg::CKP_BIT];
      assign error_irq_mask_bit_out[g] = s_r.scr_hi[g][sccr_pkg::EOC_BIT];
      assign parity_mode_out[g] = s_r.scr_hi[g][sccr_pkg::PTC_LSB +: 2];
      assign bit_order_bit_out[g] = s_r.scr_lo[g][sccr_pkg::DIR_BIT];
      assign stop_mode_out[g] = s_r.scr_lo[g][sccr_pkg::SLC_LSB +: 2];
      assign data_length_bit_out[g]    = s_r.scr_lo[g][sccr_pkg::DLS_BIT];
      assign transfer_tick_out[g]      = s_r.tick[g];
      assign framing_error_flag_out[g] = s_r.fe[g];
      assign parity_error_flag_out[g]  = s_r.pe[g];
      assign overrun_error_flag_out[g] = s_r.ov[g];
      assign transfer_irq_out[g]       = s_r.xirq[g];
      assign receive_interrupt_out[g]  = s_r.rirq[g];
      assign error_interrupt_out[g]    = s_r.eirq[g];
   end

   // ------------------------------------------------------------
   // Assertions, channel 0
   // ------------------------------------------------------------
   property p_rst_cfg;
      @(posedge ref_clk_in) disable iff (rst_in)
      $fell(rst_in) |-> s_r.scr_lo[0] == 8'h87 && s_r.scr_hi[0] == 8'h00;
   endproperty
   a_rst_cfg: assert property (p_rst_cfg)
      else $error("setting bytes wrong after reset");

   property p_rst_data;
      @(posedge ref_clk_in) disable iff (rst_in)
      $fell(rst_in) |-> s_r.div[0] == 8'h00 && s_r.dbuf[0] == 8'h00;
   endproperty
   a_rst_data: assert property (p_rst_data)
      else $error("divider or buffer not cleared by reset");

   property p_div_lock;
      @(posedge ref_clk_in) disable iff (rst_in)
      bus_wr_in && bus_addr_in == sccr_pkg::ADDR_DIV[0]
      && channel_enabled_status_in[0] |=> $stable(s_r.div[0]);
   endproperty
   a_div_lock: assert property (p_div_lock)
      else $error("divider written while channel enabled");

   property p_div_rd0;
      @(posedge ref_clk_in) disable iff (rst_in)
      bus_rd_in && bus_addr_in == sccr_pkg::ADDR_DIV[0]
      && channel_enabled_status_in[0] |=> bus_rdata_out == 8'h00;
   endproperty
   a_div_rd0: assert property (p_div_rd0)
      else $error("divider read nonzero while enabled");

   property p_clr_rd0;
      @(posedge ref_clk_in) disable iff (rst_in)
      bus_rd_in && bus_addr_in == sccr_pkg::ADDR_ERRCLR[0]
      |=> bus_rdata_out == 8'h00;
   endproperty
   a_clr_rd0: assert property (p_clr_rd0)
      else $error("clear trigger read nonzero");

   property p_clr_ov;
      @(posedge ref_clk_in) disable iff (rst_in)
      bus_wr_in && bus_addr_in == sccr_pkg::ADDR_ERRCLR[0]
      && bus_wdata_in[sccr_pkg::OVCT_BIT]
      && !overrun_set_in[0] && !(bus_wr_in && s_r.v1[0] && !tx_ready_in[0])
      |=> !overrun_error_flag_out[0];
   endproperty
   a_clr_ov: assert property (p_clr_ov)
      else $error("overrun flag not cleared");

   property p_bufempty;
      @(posedge ref_clk_in) disable iff (rst_in)
      irq_source_select_in[0] && tx_valid_out[0] && tx_ready_in[0]
      |=> transfer_irq_out[0];
   endproperty
   a_bufempty: assert property (p_bufempty)
      else $error("no buffer-empty interrupt on move");

   property p_err_route;
      @(posedge ref_clk_in) disable iff (rst_in)
      error_irq_mask_bit_out[0] && rx_valid_in[0] && parity_set_in[0]
      |=> error_interrupt_out[0] && !receive_interrupt_out[0];
   endproperty
   a_err_route: assert property (p_err_route)
      else $error("error not routed to error interrupt");

   property p_len7;
      @(posedge ref_clk_in) disable iff (rst_in)
      !data_length_bit_out[0] && !tx_valid_out[0] && bus_wr_in
      && bus_addr_in == sccr_pkg::ADDR_DBUF[0] && channel_enabled_status_in[0]
      && tx_enable_bit_out[0] |=> tx_valid_out[0] && !tx_data_out[0][7];
   endproperty
   a_len7: assert property (p_len7)
      else $error("seven-bit word kept bit 7");

   property p_even;
      @(posedge ref_clk_in) disable iff (rst_in)
      tx_valid_out[0] && $stable(parity_mode_out[0])
      && parity_mode_out[0] == sccr_pkg::PAR_EVEN
      |-> tx_parity_bit_out[0] == ^tx_data_out[0];
   endproperty
   a_even: assert property (p_even)
      else $error("even parity bit wrong");

   c_fill: cover property (@(posedge ref_clk_in) disable iff (rst_in)
      tx_valid_out[0] && !tx_buf_ready_out[0]);
   c_tick: cover property (@(posedge ref_clk_in) disable iff (rst_in)
      transfer_tick_out[0] ##2 transfer_tick_out[0]);
   c_errirq: cover property (@(posedge ref_clk_in) disable iff (rst_in)
      error_interrupt_out[0]);
endmodule : sccr_regs

// ===== sim/sccr_peer.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// Shifter model on the far side of the transmit stream
// ------------------------------------------------------------
module sccr_peer (
   input  wire logic clk_in,
   input  wire logic rst_in,
   input  wire logic stall_in,
   input  wire logic tx_valid_in,
   output logic      tx_ready_out,
   output logic      xfer_end_out
);
   logic [1:0] busy_r;
   logic       hold;

   // One frame at a time; a real shifter is busy while it shifts,
   // so the next word waits and end-of-frame lands after the stop bits
   always @(posedge clk_in) begin
      hold = stall_in;
      if (rst_in) begin
         busy_r = 2'h0;
      end else if (tx_valid_in && tx_ready_out) begin
         busy_r = 2'h3;
      end else if (busy_r != 2'h0) begin
         busy_r = busy_r - 2'h1;
      end
      #1;
      xfer_end_out = (busy_r == 2'h1);
      tx_ready_out = !rst_in && busy_r == 2'h0 && !hold
                     && ($urandom % 4 != 0);
   end
endmodule : sccr_peer

// ===== sim/serial_channel_config_regs_tb.sv
`timescale 1ns/1ps
module serial_channel_config_regs_tb;
   // ------------------------------------------------------------
   // Stimulus, observed outputs and bookkeeping
   // ------------------------------------------------------------
   logic            clk = 1'b0;
   logic            rst = 1'b1;
   logic [19:0]     addr = 20'h00000;
   logic            wr_s = 1'b0;
   logic            rd_s = 1'b0;
   logic [7:0]      wdata = 8'h00;
   logic [1:0]      en = 2'h0;
   logic [1:0]      isel = 2'h0;
   logic [1:0]      rx_v = 2'h0;
   logic [1:0][7:0] rx_d = 16'h0000;
   logic [1:0]      fset = 2'h0;
   logic [1:0]      pset = 2'h0;
   logic            stall = 1'b1;
   logic [1:0]      tcs = 2'h0;
   logic [1:0]      pin = 2'h0;
   logic            p_rdy;
   logic            p_end;
   logic [7:0]      rdata;
   logic [1:0]      txv, tbr, par, tick, bo, dl, txen, rxen, dap, ckp;
   logic [1:0]      eoc, fef, pef, ovf, tirq, rirq, eirq;
   logic [1:0][1:0] pm, sm;
   logic [1:0][7:0] txd;
   logic [7:0]      q_rd[$];
   logic [7:0]      q_tx[$];
   int              n_fail = 0;
   int              num_checks = 0;
   int              cyc = 0;
   int              t_take = -100;
   bit              rd_pend = 1'b0;

   always #5 clk = ~clk;

   sccr_regs sccr_regs_inst (
      .ref_clk_in(clk), .rst_in(rst), .bus_addr_in(addr),
      .bus_wr_in(wr_s), .bus_rd_in(rd_s), .bus_wdata_in(wdata),
      .bus_rdata_out(rdata), .channel_enabled_status_in(en),
      .irq_source_select_in(isel), .transfer_clock_select_in(tcs),
      .serial_clock_pin_in(pin), .tx_ready_in({1'b0, p_rdy}),
      .rx_valid_in(rx_v), .rx_data_in(rx_d),
      .xfer_end_in({1'b0, p_end}), .framing_set_in(fset),
      .parity_set_in(pset), .overrun_set_in(2'h0),
      .tx_data_out(txd), .tx_valid_out(txv), .tx_buf_ready_out(tbr),
      .tx_parity_bit_out(par), .tx_enable_bit_out(txen),
      .rx_enable_bit_out(rxen), .data_phase_bit_out(dap),
      .clock_phase_bit_out(ckp), .error_irq_mask_bit_out(eoc),
      .parity_mode_out(pm), .bit_order_bit_out(bo), .stop_mode_out(sm),
      .data_length_bit_out(dl), .transfer_tick_out(tick),
      .framing_error_flag_out(fef), .parity_error_flag_out(pef),
      .overrun_error_flag_out(ovf), .transfer_irq_out(tirq),
      .receive_interrupt_out(rirq), .error_interrupt_out(eirq)
   );

   sccr_peer sccr_peer_inst (
      .clk_in(clk), .rst_in(rst), .stall_in(stall),
      .tx_valid_in(txv[0]), .tx_ready_out(p_rdy), .xfer_end_out(p_end)
   );

   // ------------------------------------------------------------
   // Compare, bus and wait helpers
   // ------------------------------------------------------------
   task automatic chk_byte(input string w, input logic [7:0] e,
                           input logic [7:0] g);
      num_checks++;
      if (g !== e) begin
         n_fail++;
         $display("wrong value %s expected %h seen %h", w, e, g);
      end
   endtask : chk_byte

   task automatic chk_bit(input string w, input logic e, input logic g);
      chk_byte(w, {7'h00, e}, {7'h00, g});
   endtask : chk_bit

   task automatic step();
      @(posedge clk);
      #1;
   endtask : step

   task automatic wr(input logic [19:0] a, input logic [7:0] d);
      step();
      addr = a;
      wdata = d;
      wr_s = 1'b1;
      step();
      wr_s = 1'b0;
   endtask : wr

   task automatic rd(input logic [19:0] a, input logic [7:0] e);
      q_rd.push_back(e);
      step();
      addr = a;
      rd_s = 1'b1;
      step();
      rd_s = 1'b0;
   endtask : rd

   task automatic run0(input logic v);
      step();
      en[0] = v;
   endtask : run0

   task automatic summarize();
      repeat (3) @(posedge clk);
      $display("checks %0d mismatches %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : summarize

   // A used-up wait bound is a mismatch and ends the run
   task automatic bound(input int n, input int lim);
      if (n >= lim) begin
         n_fail++;
         $display("wrong value wait bound expected %0d seen %0d", lim, n);
         summarize();
      end
   endtask : bound

   task automatic fin(input string s);
      $display("test %s done: %0d checks %0d mismatches", s, num_checks,
               n_fail);
   endtask : fin

   // Release the shifter until every noted word has left
   task automatic drain();
      int n;
      n = 0;
      stall = 1'b0;
      while (q_tx.size() != 0 && n < 500) begin
         step();
         n++;
      end
      bound(n, 500);
      repeat (5) step();
      stall = 1'b1;
   endtask : drain

   // Cycles from one transfer tick to the next
   task automatic tick_gap(input int e);
      int n;
      n = 0;
      while (tick[0] !== 1'b1 && n < 300) begin
         step();
         n++;
      end
      bound(n, 300);
      n = 0;
      do begin
         step();
         n++;
      end while (tick[0] !== 1'b1 && n < 300);
      bound(n, 300);
      chk_bit("tick gap", 1'b1, n == e);
   endtask : tick_gap

   // Watcher: takes the oldest note off its queue as a result appears;
   // end-of-frame delay is four cycles, buffer-empty delay one
   always @(posedge clk) begin
      if (rd_pend) begin
         chk_byte("read data", q_rd.size() ? q_rd.pop_front() : 8'hXX,
                  rdata);
      end
      rd_pend = rd_s;
      if (tirq[0] === 1'b1) begin
         chk_bit("irq delay", 1'b1,
                 (cyc - t_take) == (isel[0] ? 1 : 4));
      end
      if (txv[0] && p_rdy) begin
         chk_byte("tx word", q_tx.size() ? q_tx.pop_front() : 8'hXX,
                  txd[0]);
         t_take = cyc;
      end
      cyc++;
   end

   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial begin
      logic [7:0] d;
      logic [7:0] e;
      logic [7:0] dv [2];
      dv = '{8'h01, 8'hFF};
      void'($urandom(60));
      repeat (6) @(posedge clk);
      #1;
      rst = 1'b0;
      chk_byte("reset fields", 8'hFC, {bo, dl, tbr, txen});
      for (int c = 0; c < 2; c++) begin
         rd(sccr_pkg::ADDR_SCRL[c], 8'h87);
         rd(sccr_pkg::ADDR_SCRH[c], 8'h00);
         rd(sccr_pkg::ADDR_DBUF[c], 8'h00);
         rd(sccr_pkg::ADDR_DIV[c], 8'h00);
         rd(sccr_pkg::ADDR_ERRCLR[c], 8'h00);
         for (int k = 0; k < 2; k++) begin
            d = k ? 8'h00 : 8'hFF;
            e = (d & sccr_pkg::SCRL_WMASK[c]) | sccr_pkg::SCRL_ONES;
            wr(sccr_pkg::ADDR_SCRL[c], d);
            rd(sccr_pkg::ADDR_SCRL[c], e);
            chk_byte("stop code", {6'h00, e[5:4]}, {6'h00, sm[c]});
            chk_byte("order len", {6'h00, e[7], e[0]},
                     {6'h00, bo[c], dl[c]});
         end
         wr(sccr_pkg::ADDR_SCRL[c], 8'h87);
      end
      rd(20'h00000, 8'h00);
      for (int k = 0; k < 4; k++) begin
         d = {k[1:0], k[1:0], 1'b0, k[0], k[1:0]};
         wr(sccr_pkg::ADDR_SCRH[0], d);
         rd(sccr_pkg::ADDR_SCRH[0], d);
         chk_byte("high fields", d, {txen[0], rxen[0], dap[0], ckp[0],
                  1'b0, eoc[0], pm[0]});
      end
      fin("setting registers");
      for (int i = 0; i < 2; i++) begin
         wr(sccr_pkg::ADDR_DIV[0], dv[i]);
         run0(1'b1);
         tick_gap(2 * (dv[i][7:1] + 1));
         rd(sccr_pkg::ADDR_DIV[0], 8'h00);
         wr(sccr_pkg::ADDR_DIV[0], 8'h5A);
         run0(1'b0);
         rd(sccr_pkg::ADDR_DIV[0], dv[i]);
      end
      fin("divider");
      // Pin clock: ticks only on a synchronised rising pin edge
      tcs[0] = 1'b1;
      run0(1'b1);
      repeat (4) step();
      chk_bit("pin tick", 1'b0, tick[0]);
      pin[0] = 1'b1;
      repeat (3) step();
      chk_bit("pin tick", 1'b1, tick[0]);
      step();
      chk_bit("pin tick", 1'b0, tick[0]);
      pin[0] = 1'b0;
      run0(1'b0);
      tcs[0] = 1'b0;
      fin("pin clock");
      for (int p = 0; p < 4; p++) begin
         wr(sccr_pkg::ADDR_SCRH[0], 8'h80 | p[7:0]);
         isel[0] = p[0];
         run0(1'b1);
         d = $urandom;
         q_tx.push_back(d);
         wr(sccr_pkg::ADDR_DBUF[0], d);
         repeat (2) step();
         e = {7'h00, p[1] & (^d ^ p[0])};
         chk_byte("parity bit", e, {7'h00, par[0]});
         drain();
         run0(1'b0);
      end
      wr(sccr_pkg::ADDR_SCRL[0], 8'h86);
      run0(1'b1);
      for (int i = 0; i < 3; i++) begin
         d = $urandom;
         d[7] = 1'b1;
         if (i < 2) begin
            q_tx.push_back({1'b0, d[6:0]});
         end
         wr(sccr_pkg::ADDR_DBUF[0], d);
      end
      step();
      chk_byte("full overrun", 8'h01, {6'h00, tbr[0], ovf[0]});
      drain();
      wr(sccr_pkg::ADDR_ERRCLR[0], 8'h01);
      step();
      chk_bit("overrun flag", 1'b0, ovf[0]);
      rd(sccr_pkg::ADDR_ERRCLR[0], 8'h00);
      run0(1'b0);
      fin("transmit stream");
      wr(sccr_pkg::ADDR_SCRL[0], 8'h87);
      for (int m = 0; m < 2; m++) begin
         wr(sccr_pkg::ADDR_SCRH[0], 8'h40 | (m[7:0] << 2));
         run0(1'b1);
         d = $urandom;
         step();
         rx_v[0] = 1'b1;
         rx_d[0] = d;
         pset[0] = 1'b1;
         step();
         rx_v[0] = 1'b0;
         pset[0] = 1'b0;
         chk_byte("irq pair", {6'h00, m[0], !m[0]},
                  {6'h00, eirq[0], rirq[0]});
         chk_bit("parity flag", 1'b1, pef[0]);
         rd(sccr_pkg::ADDR_DBUF[0], d);
         wr(sccr_pkg::ADDR_ERRCLR[0], 8'h02);
         step();
         chk_bit("parity flag", 1'b0, pef[0]);
         run0(1'b0);
      end
      step();
      fset = 2'h3;
      step();
      fset = 2'h0;
      chk_byte("framing flags", 8'h02, {6'h00, fef});
      wr(sccr_pkg::ADDR_ERRCLR[1], 8'h04);
      step();
      chk_byte("framing flags", 8'h00, {6'h00, fef});
      fin("receive and errors");
      summarize();
   end
endmodule : serial_channel_config_regs_tb
